// ---- epi_pkg.sv ----
// Package: register map, field layout and state record of the external pin interrupt unit
package epi_pkg;
  // Register byte offsets on the AHB-Lite bus
  localparam logic [7:0] OFS_MAIN = 8'h00;
  localparam logic [7:0] OFS_EXT  = 8'h04;
  localparam logic [7:0] OFS_ENA  = 8'h08;
  localparam logic [7:0] OFS_FLG  = 8'h0c;
  localparam logic [7:0] OFS_MSKU = 8'h10;
  localparam logic [7:0] OFS_MSKL = 8'h14;
  localparam logic [7:0] OFS_PIN  = 8'h18;
  // Enable and flag bit positions, shared by both registers
  localparam int B_S1 = 7;
  localparam int B_S0 = 6;
  localparam int B_S2 = 5;
  localparam int B_G1 = 4;
  localparam int B_G0 = 3;
  localparam logic [7:0] EVT_MASK = 8'hf8;
  // Sense field positions in the main control register and select bit of the extension register
  localparam int B_S1_HI = 3;
  localparam int B_S1_LO = 2;
  localparam int B_S0_HI = 1;
  localparam int B_S0_LO = 0;
  localparam logic [7:0] MAIN_MASK = 8'h0f;
  localparam int B_S2_SEL = 0;
  // Two-bit sense encodings of sources 0 and 1
  localparam logic [1:0] SNS_LOW  = 2'b00;
  localparam logic [1:0] SNS_ANY  = 2'b01;
  localparam logic [1:0] SNS_FALL = 2'b10;
  localparam logic [1:0] SNS_RISE = 2'b11;
  // Reset value, pin count and source count
  localparam logic [7:0] RST_REG = 8'h00;
  localparam int         N_PIN   = 19;
  localparam int         N_SRC   = 5;
  // Whole state of the unit
  typedef struct packed {
    logic [N_PIN-1:0] sy1;
    logic [N_PIN-1:0] sy2;
    logic [N_PIN-1:0] prv;
    logic             v2;
    logic [7:0]       main;
    logic             sel2;
    logic [7:0]       ena;
    logic [7:0]       flg;
    logic [7:0]       msku;
    logic [7:0]       mskl;
    logic             busy;
    logic             wr;
    logic [7:0]       addr;
    logic             hrdy;
    logic [31:0]      rdata;
    logic [N_SRC-1:0] irq;
  } epi_state_s;
endpackage : epi_pkg

// ---- epi_unit.sv ----
// Modules: external pin interrupt unit with AHB-Lite register slave, change-group detector
// Function
// - Source 1 sense: 00 low level, 01 any change, 10 falling, 11 rising.
// - Source 0 sense uses the same four encodings.
// - Sources 0 and 1 request only with global flag and own enable set.
// - Sources 0 and 1 sampled on the clock before edge detection.
// - Source 2 sense bit: cleared falling edge, set rising edge, no level.
// - Source 2 edges caught regardless of sense path, pulses over 50 ns.
// - Enable bit 7 gates source 1 onto its own vector.
// - Enable bit 6 gates source 0 onto its own vector.
// - Enable bit 5 gates source 2 onto its own vector.
// - Detection keeps working while a dedicated pin is driven as output.
// - Enable bit 4 gates change group 1 over upper masked inputs.
// - Enable bit 3 gates change group 0 over lower masked inputs.
// - Triggers set pending flags; vector or write-one clears; level reads zero.
// - Level mode requests continuously while the pin stays low.
// - Each mask bit and the group enable together admit a change.
// - Level detection needs no edge history; source 2 and change detection compare with the previous sample.
module epi_unit
(
  input  wire logic        I_MCLK,
  input  wire logic        I_RST,
  input  wire logic        I_HSEL,
  input  wire logic [7:0]  I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic [31:0] I_HWDATA,
  input  wire logic        I_HREADY,
  output logic      [31:0] O_HRDATA,
  output logic             O_HREADYOUT,
  output logic             O_HRESP,
  input  wire logic        I_EXT0,
  input  wire logic        I_EXT1,
  input  wire logic        I_EXT2,
  input  wire logic [7:0]  I_CHG_UP,
  input  wire logic [7:0]  I_CHG_LO,
  input  wire logic        I_GIE,
  input  wire logic [4:0]  I_VEC_ACK,
  output logic      [4:0]  O_IRQ
);

  epi_pkg::epi_state_s q;
  epi_pkg::epi_state_s d;

  // Sense decode shared by sources 0 and 1
  function automatic logic sense_hit
  (
    input logic [1:0] mode,
    input logic       cur,
    input logic       old
  );
    logic hit;
    hit = 1'b0;
    case (mode)
      epi_pkg::SNS_LOW:  hit = 1'b0;
      epi_pkg::SNS_ANY:  hit = cur ^ old;
      epi_pkg::SNS_FALL: hit = ~cur & old;
      epi_pkg::SNS_RISE: hit = cur & ~old;
      default:           hit = 1'b0;
    endcase
    return hit;
  endfunction : sense_hit

  // Register read mux; unmapped offsets read zero
  function automatic logic [31:0] read_reg
  (
    input epi_pkg::epi_state_s s,
    input logic [7:0]          a
  );
    logic [7:0] v;
    v = 8'h00;
    case (a)
      epi_pkg::OFS_MAIN: v = s.main;
      epi_pkg::OFS_EXT:  v = {7'h00, s.sel2};
      epi_pkg::OFS_ENA:  v = s.ena;
      epi_pkg::OFS_FLG:  v = s.flg;
      epi_pkg::OFS_MSKU: v = s.msku;
      epi_pkg::OFS_MSKL: v = s.mskl;
      epi_pkg::OFS_PIN:  v = {5'h00, s.sy2[18:16]};
      default:           v = 8'h00;
    endcase
    return {24'h000000, v};
  endfunction : read_reg

  logic [1:0]  mode1;
  logic [1:0]  mode0;
  logic [18:0] cur;
  logic [18:0] old;
  logic        v_now;
  logic [7:0]  set;
  logic [7:0]  clr;
  logic [7:0]  hold;
  logic [7:0]  lvl;
  logic [7:0]  req;
  logic        wsel;
  logic [7:0]  wbyte;
  logic        grp1_hit;
  logic        grp0_hit;

  // Upper change group; one detector shape serves both groups
  epi_chg_group
  #(
    .W (8)
  )
  u_epi_chg_group_up
  (
    .i_en   (q.ena[epi_pkg::B_G1]),
    .i_cur  (q.sy2[15:8]),
    .i_old  (q.prv[15:8]),
    .i_mask (q.msku),
    .o_hit  (grp1_hit)
  );

  // Lower change group
  epi_chg_group
  #(
    .W (8)
  )
  u_epi_chg_group_lo
  (
    .i_en   (q.ena[epi_pkg::B_G0]),
    .i_cur  (q.sy2[7:0]),
    .i_old  (q.prv[7:0]),
    .i_mask (q.mskl),
    .o_hit  (grp0_hit)
  );

  // Next state of the whole unit
  always_comb
  begin
    d     = q;
    mode1 = {q.main[epi_pkg::B_S1_HI], q.main[epi_pkg::B_S1_LO]};
    mode0 = {q.main[epi_pkg::B_S0_HI], q.main[epi_pkg::B_S0_LO]};
    cur   = q.sy2;
    old   = q.prv;
    set   = 8'h00;
    clr   = 8'h00;
    hold  = 8'h00;
    lvl   = 8'h00;
    req   = 8'h00;
    wsel  = 1'b0;
    wbyte = I_HWDATA[7:0];

    // First stage takes the pins as inputs whatever their port direction
    d.sy1[18]   = I_EXT1;
    d.sy1[17]   = I_EXT0;
    d.sy1[16]   = I_EXT2;
    d.sy1[15:8] = I_CHG_UP;
    d.sy1[7:0]  = I_CHG_LO;

    // Only the second stage reads the first, so a metastable value settles
    d.sy2 = q.sy1;

    // One-sample history for the source 0 and 1 edge detectors and both change groups
    d.prv = q.sy2;

    // Edge and change detection on the sampled pins
    set[epi_pkg::B_S1] = sense_hit(mode1, cur[18], old[18]);
    set[epi_pkg::B_S0] = sense_hit(mode0, cur[17], old[17]);

    // Polarity-folded source 2: a sense change can itself fire
    v_now = q.sel2 ? cur[16] : ~cur[16];
    d.v2  = v_now;
    set[epi_pkg::B_S2] = v_now & ~q.v2;

    // Pin change groups admit masked bits only while enabled
    set[epi_pkg::B_G1] = grp1_hit;
    set[epi_pkg::B_G0] = grp0_hit;

    // Vector acknowledge clears its flag
    clr[epi_pkg::B_S1] = I_VEC_ACK[4];
    clr[epi_pkg::B_S0] = I_VEC_ACK[3];
    clr[epi_pkg::B_S2] = I_VEC_ACK[2];
    clr[epi_pkg::B_G1] = I_VEC_ACK[1];
    clr[epi_pkg::B_G0] = I_VEC_ACK[0];

    // AHB data phase completes one wait state after the address phase
    d.hrdy = 1'b1;
    if (q.busy)
    begin
      d.busy  = 1'b0;
      d.rdata = q.wr ? 32'h00000000 : read_reg(q, q.addr);
      wsel    = q.wr;
    end

    // Register writes; flag writes of one clear
    if (wsel)
    begin
      case (q.addr)
        epi_pkg::OFS_MAIN: d.main = wbyte & epi_pkg::MAIN_MASK;
        epi_pkg::OFS_EXT:  d.sel2 = wbyte[epi_pkg::B_S2_SEL];
        epi_pkg::OFS_ENA:  d.ena  = wbyte & epi_pkg::EVT_MASK;
        epi_pkg::OFS_FLG:  clr    = clr | (wbyte & epi_pkg::EVT_MASK);
        epi_pkg::OFS_MSKU: d.msku = wbyte;
        epi_pkg::OFS_MSKL: d.mskl = wbyte;
        default:           d.main = q.main;
      endcase
    end

    // New address phase, taken only while the bus shows ready on I_HREADY
    if (I_HSEL && I_HREADY && I_HTRANS[1])
    begin
      d.busy = 1'b1;
      d.hrdy = 1'b0;
      d.wr   = I_HWRITE;
      d.addr = {I_HADDR[7:2], 2'b00};
    end

    // Set wins over clear so a same-cycle event is kept
    d.flg = ((q.flg & ~clr) | set) & epi_pkg::EVT_MASK;

    // Level mode: flag held clear, live low level requests instead
    if (mode1 == epi_pkg::SNS_LOW)
    begin
      d.flg[epi_pkg::B_S1] = 1'b0;
      lvl[epi_pkg::B_S1]   = ~cur[18];
    end

    // Source 0 follows the same level rule
    if (mode0 == epi_pkg::SNS_LOW)
    begin
      d.flg[epi_pkg::B_S0] = 1'b0;
      lvl[epi_pkg::B_S0]   = ~cur[17];
    end

    // Request gating by own enable and the global flag
    hold = q.flg | lvl;
    req  = hold & q.ena & {8{I_GIE}};
    // Dedicated sources, one vector each
    d.irq[4] = req[epi_pkg::B_S1];
    d.irq[3] = req[epi_pkg::B_S0];
    d.irq[2] = req[epi_pkg::B_S2];

    // Change groups, one vector per group
    d.irq[1] = req[epi_pkg::B_G1];
    d.irq[0] = req[epi_pkg::B_G0];
  end

  // State register; pins reset low, so a pin high at release is seen as an edge later
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      // Pin history starts low; a pin high at release reads as an edge
      q.sy1   <= '0;
      q.sy2   <= '0;
      q.prv   <= '0;
      // Fold matches a low pin under falling-edge sense, so no false edge
      q.v2    <= 1'b1;
      // Software registers
      q.main  <= epi_pkg::RST_REG;
      q.sel2  <= 1'b0;
      q.ena   <= epi_pkg::RST_REG;
      q.flg   <= epi_pkg::RST_REG;
      q.msku  <= epi_pkg::RST_REG;
      q.mskl  <= epi_pkg::RST_REG;
      // Bus idle with ready shown
      q.busy  <= 1'b0;
      q.wr    <= 1'b0;
      q.addr  <= 8'h00;
      q.hrdy  <= 1'b1;
      q.rdata <= 32'h00000000;
      // No request until a flag or level is seen
      q.irq   <= 5'h00;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from flops; the response is always OKAY
  assign O_HRDATA    = q.rdata;
  assign O_HREADYOUT = q.hrdy;
  assign O_IRQ       = q.irq;

  // Error response never raised; kept a flop so the pin stays registered
  always_ff @(posedge I_MCLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_HRESP <= 1'b0;
    end
    else
    begin
      O_HRESP <= 1'b0;
    end
  end

endmodule : epi_unit

// Masked change detector, one per pin-change group
module epi_chg_group
#(
  parameter int W = 8
)
(
  input  wire logic         i_en,
  input  wire logic [W-1:0] i_cur,
  input  wire logic [W-1:0] i_old,
  input  wire logic [W-1:0] i_mask,
  output logic              o_hit
);

  // Toggle counts only on a masked input while the group is enabled
  assign o_hit = i_en & (|((i_cur ^ i_old) & i_mask));

endmodule : epi_chg_group

// ---- epi_unit_checker.sv ----
// Port checker for the pin interrupt unit
module epi_unit_checker
(
  input wire logic        I_MCLK,
  input wire logic        I_RST,
  input wire logic        I_HSEL,
  input wire logic [1:0]  I_HTRANS,
  input wire logic        I_HREADY,
  input wire logic        I_GIE,
  input wire logic [31:0] O_HRDATA,
  input wire logic        O_HREADYOUT,
  input wire logic        O_HRESP,
  input wire logic [4:0]  O_IRQ
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge I_MCLK);
  endclocking
  default disable iff (I_RST);
  // Transfer accepted by the slave
  wire tk = I_HSEL & I_HREADY & I_HTRANS[1];
  chk_resp_okay: assert property (O_HRESP == 1'b0) else $error("bad response");
  chk_one_wait: assert property (tk |=> !O_HREADYOUT ##1 O_HREADYOUT) else $error("wait state");
  chk_rdy_back: assert property (!O_HREADYOUT |=> O_HREADYOUT) else $error("ready stuck");
  chk_rd_upper: assert property (O_HRDATA[31:8] == 24'h0) else $error("upper bits");
  chk_rd_hold: assert property ($changed(O_HRDATA) |-> !$past(O_HREADYOUT)) else $error("rdata");
  chk_gie_gate: assert property (!I_GIE |=> O_IRQ == 5'h0) else $error("no global");
  chk_irq_cause: assert property ($rose(O_IRQ[3]) |-> $past(I_GIE)) else $error("early");
  chk_rst_quiet: assert property ($fell(I_RST) |-> (O_IRQ == 5'h0) [*3]) else $error("irq");
endmodule : epi_unit_checker
bind epi_unit epi_unit_checker u_chk (.I_MCLK, .I_RST, .I_HSEL, .I_HTRANS, .I_HREADY,
  .I_GIE, .O_HRDATA, .O_HREADYOUT, .O_HRESP, .O_IRQ);

// ---- epi_core_model.sv ----
// Core model: takes each raised request once, or holds off
module epi_core_model
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_take,
  input  wire logic [4:0] i_irq,
  output logic      [4:0] o_ack
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] hold_q;
  // Pause a vector until its flag has had time to clear
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      {o_ack, hold_q} <= 10'h0;
    else
      {o_ack, hold_q} <= {i_take ? i_irq & ~o_ack & ~hold_q : 5'h0, o_ack};
  end
endmodule : epi_core_model

// ---- epi_unit_tb.sv ----
// Self-checking bench for the pin interrupt unit
module epi_unit_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst, hsel, hwr, gie, take, e0, e1, e2, rdy;
  logic [1:0]  htr;
  logic [4:0]  irq, ack;
  logic [7:0]  addr, cu, cl;
  logic [31:0] wd, rdat;
  int          n_fail, cmp_count;
  epi_unit u_epi_unit (.I_MCLK(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(addr),
    .I_HTRANS(htr), .I_HWRITE(hwr), .I_HSIZE(3'h2), .I_HWDATA(wd), .I_HREADY(rdy),
    .O_HRDATA(rdat), .O_HREADYOUT(rdy), .O_HRESP(), .I_EXT0(e0), .I_EXT1(e1), .I_EXT2(e2),
    .I_CHG_UP(cu), .I_CHG_LO(cl), .I_GIE(gie), .I_VEC_ACK(ack), .O_IRQ(irq));
  epi_core_model u_epi_core_model (.i_clk(clk), .i_rst(rst), .i_take(take), .i_irq(irq),
    .o_ack(ack));
  task print_verdict;
    $display("mismatches %0d of %0d compares", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Ready seen at the falling edge is what the next rising edge samples
  task phase(output logic [31:0] d);
    logic r;
    r = 1'b0;
    for (int n = 0; n < 20 && !r; n++)
    begin
      @(negedge clk);
      r = rdy;
      d = rdat;
      @(posedge clk);
    end
    if (!r)
    begin
      n_fail++;
      print_verdict;
    end
  endtask : phase
  task bus(input logic w, input logic [7:0] a, input logic [7:0] v, output logic [31:0] d);
    hsel <= 1'b1;
    htr  <= 2'h2;
    addr <= a;
    hwr  <= w;
    phase(d);
    htr  <= 2'h0;
    wd   <= {24'h0, v};
    phase(d);
  endtask : bus
  task wr(input logic [7:0] a, input logic [7:0] v);
    logic [31:0] d;
    bus(1'b1, a, v, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    bus(1'b0, a, 8'h0, d);
    chk(d, {24'h0, e});
  endtask : rd
  // Long enough for synchroniser, flag and request stages
  task irqc(input logic [4:0] e);
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk({27'h0, irq}, {27'h0, e});
    @(posedge clk);
  endtask : irqc
  // Each edge sense mode against each edge; flags set while disabled
  task t_edge(input int s);
    logic [1:0] m [6];
    logic [5:0] x;
    m = '{2'b11, 2'b11, 2'b10, 2'b10, 2'b01, 2'b01};
    x = 6'b110110;
    for (int k = 0; k < 6; k++)
    begin
      wr(epi_pkg::OFS_MAIN, 8'(m[k]) << (2 * s));
      rd(epi_pkg::OFS_MAIN, 8'(m[k]) << (2 * s));
      wr(epi_pkg::OFS_FLG, 8'hff);
      {e1, e0} <= s ? {k[0], 1'b1} : {1'b1, k[0]};
      repeat (5) @(posedge clk);
      rd(epi_pkg::OFS_FLG, {x[k], 7'h0} >> (1 - s));
    end
  endtask : t_edge
  // Source 0 to core, global flag gate, vector clears; then level on source 1
  task t_irq;
    wr(epi_pkg::OFS_MAIN, 8'h02);
    wr(epi_pkg::OFS_FLG, 8'hff);
    wr(epi_pkg::OFS_ENA, 8'h40);
    gie <= 1'b1;
    e0  <= 1'b0;
    irqc(5'h08);
    gie <= 1'b0;
    irqc(5'h00);
    {take, gie} <= 2'h3;
    irqc(5'h00);
    take <= 1'b0;
    wr(epi_pkg::OFS_MAIN, 8'h00);
    wr(epi_pkg::OFS_ENA, 8'h80);
    e1 <= 1'b0;
    irqc(5'h10);
    rd(epi_pkg::OFS_FLG, 8'h00);
    e1 <= 1'b1;
    irqc(5'h00);
  endtask : t_irq
  // Source 2 per edge select, reprogrammed in the safe order
  task t_src2;
    for (int v = 1; v >= 0; v--)
    begin
      wr(epi_pkg::OFS_ENA, 8'h00);
      wr(epi_pkg::OFS_EXT, 8'(v));
      rd(epi_pkg::OFS_EXT, 8'(v));
      wr(epi_pkg::OFS_FLG, 8'hff);
      wr(epi_pkg::OFS_ENA, 8'h20);
      irqc(5'h00);
      e2 <= v[0];
      irqc(5'h04);
    end
  endtask : t_src2
  // Only masked inputs of an enabled group count
  task t_group;
    wr(epi_pkg::OFS_ENA, 8'h18);
    wr(epi_pkg::OFS_MSKL, 8'h01);
    wr(epi_pkg::OFS_MSKU, 8'h80);
    cl <= 8'h02;
    irqc(5'h00);
    {cu, cl} <= 16'h8003;
    irqc(5'h03);
    wr(epi_pkg::OFS_FLG, 8'h18);
    irqc(5'h00);
    rd(epi_pkg::OFS_MSKU, 8'h80);
    rd(epi_pkg::OFS_MSKL, 8'h01);
    wr(epi_pkg::OFS_ENA, 8'h08);
    cu <= 8'h00;
    irqc(5'h00);
    rd(epi_pkg::OFS_FLG, 8'h20);
  endtask : t_group
  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Reset, register map, then the scenarios
  initial
  begin
    {rst, e0, e1} = 3'h7;
    {hsel, hwr, gie, take, e2, htr} = 7'h0;
    {addr, cu, cl, wd} = 56'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wr(8'h1c, 8'hff);
    wr(epi_pkg::OFS_ENA, 8'h07);
    for (int a = 0; a < 32; a += 4)
      rd(8'(a), a == 24 ? 8'h06 : 8'h00);
    t_edge(0);
    t_edge(1);
    t_irq;
    t_src2;
    t_group;
    print_verdict;
  end
endmodule : epi_unit_tb
